/* File: verilog/rpfc_cfg.svh */
// Purpose: constants for the reset and supply-fail controller
// Assumes: 100 MHz clock, 32-bit APB
// Notes:   included by bare name
`ifndef RPFC_CFG_SVH
`define RPFC_CFG_SVH

// ---------------------------------------------------------------
// register map (byte addresses)
// ---------------------------------------------------------------
`define RPFC_ADDR_PFCTL     12'h000
`define RPFC_ADDR_CFG       12'h004
`define RPFC_ADDR_STATUS    12'h008
`define RPFC_ADDR_CAUSE     12'h00c
`define RPFC_ADDR_RAMBANK   12'h010
`define RPFC_ADDR_PROGMODE  12'h014

// supply fail control fields
`define RPFC_PF_EN_BIT      0
`define RPFC_PF_MODE_BIT    1
`define RPFC_PF_FLAG_BIT    2
`define RPFC_PFCTL_RST      3'h0

// configuration area fields
`define RPFC_CFG_POR_BIT    0
`define RPFC_CFG_PORT_BIT   1
`define RPFC_CFG_ONP_BIT    2
`define RPFC_CFG_CLK_BIT    3
`define RPFC_CFG_LOCK_BIT   4
`define RPFC_CFG_RST        5'h00

// reset values of processor state
`define RPFC_RAMBANK_RST    8'h00
`define RPFC_DPAGE_RST      1'b0
`define RPFC_CLKSEL_MAIN    1'b0

// timing: clock period and start-up delay
`define RPFC_CLK_NS         10
`define RPFC_PF_FILT_NS     100
`define RPFC_PF_FILT_CYC    ((`RPFC_PF_FILT_NS + `RPFC_CLK_NS - 1) / `RPFC_CLK_NS)
`define RPFC_EXT_MIN_CYC    8
`define RPFC_STARTUP_US     65500
`define RPFC_OSC_NS         250
`define RPFC_STARTUP_CYC    ((`RPFC_STARTUP_US * 1000 + `RPFC_CLK_NS - 1) / `RPFC_CLK_NS)
`define RPFC_EXTRA_CYC      ((7 * `RPFC_OSC_NS + `RPFC_CLK_NS - 1) / `RPFC_CLK_NS)

`endif

/* File: verilog/rpfc_pkg.sv */
// Purpose: types for the reset and supply-fail controller
// Assumes: nothing
// Notes:   constants live in rpfc_cfg.svh
`default_nettype none
package rpfc_pkg;
  // reset sources, one bit each
  typedef struct packed {
    logic addr_fail;
    logic supply_fail;
    logic watchdog;
    logic ext_pin;
    logic power_on;
  } rpfc_src_t;

  // sequencer states
  typedef enum logic [1:0] {
    RPFC_ST_HOLD  = 2'b00,
    RPFC_ST_COUNT = 2'b01,
    RPFC_ST_RUN   = 2'b10
  } rpfc_state_t;
endpackage : rpfc_pkg
`default_nettype wire

/* File: verilog/rpfc_filter.sv */
// Purpose: level must persist a number of cycles before it is passed on
// Assumes: input synchronous to the clock
// Notes:   used for supply-fail debounce
`timescale 1ns/1ps
`default_nettype none
module rpfc_filter #(
  parameter int unsigned CYCLES = 10
) (
  input  wire logic I_CLK,
  input  wire logic I_RESET_N,
  input  wire logic i_level,
  output logic      o_hit
);
  localparam int W = $clog2(CYCLES + 1);
  logic [W-1:0] cnt_r;

  // count consecutive cycles of the level, clear on any gap
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      cnt_r <= '0;
    end else if (!i_level) begin
      cnt_r <= '0;
    end else if (cnt_r != W'(CYCLES)) begin
      cnt_r <= cnt_r + W'(1);
    end
  end

  assign o_hit = (cnt_r == W'(CYCLES));
endmodule : rpfc_filter
`default_nettype wire

/* File: verilog/rpfc_delay.sv */
// Purpose: start-up delay counter, restarts on every reset request
// Assumes: counts on the main oscillator clock
// Notes:   o_done is a level while the count has expired
`timescale 1ns/1ps
`default_nettype none
module rpfc_delay #(
  parameter int unsigned CYCLES = 1000
) (
  input  wire logic I_CLK,
  input  wire logic I_RESET_N,
  input  wire logic i_restart,
  output logic      o_done
);
  localparam int W = $clog2(CYCLES + 1);
  logic [W-1:0] cnt_r;

  // any new request restarts the count from zero
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      cnt_r <= '0;
    end else if (i_restart) begin
      cnt_r <= '0;
    end else if (cnt_r != W'(CYCLES)) begin
      cnt_r <= cnt_r + W'(1);
    end
  end

  assign o_done = (cnt_r == W'(CYCLES)) && !i_restart;
endmodule : rpfc_delay
`default_nettype wire

/* File: verilog/rpfc_top.sv */
// Purpose: merges reset sources, runs start-up delay, supply-fail control
// Assumes: one 100 MHz clock, inputs synchronous, APB register access
// Notes:   the internal reset drives the core; register file is on I_RESET_N
//
// Overview of operation
// (RQ1) five sources reset the device: power-on, pin, watchdog, supply fail, address fail
// (RQ2) power-on detector holds reset until supply is high enough
// (RQ3) with power-on and port options set, reset pin becomes a plain input bit
// (RQ4) reset clears ram bank and direct-page flag, selects main clock
// (RQ5) external circuit holds reset pin low at least eight oscillator periods; the bench driver holds it low at least 8 clock cycles (80 ns)
// (RQ6) after release wait 65.5 ms plus seven oscillator periods before running
// (RQ7) reset leaves internal RAM untouched; only core state is initialised
// (RQ8) reset ends when the reset pin returns high, then start-up proceeds
// (RQ9) execution starts at vector, high byte at top address, low byte below
// (RQ10) instruction fetch from invalid code or RAM area causes a reset
// (RQ11) supply-fail control register enables or disables detection
// (RQ12) supply low for 100 ns resets or freezes, chosen by mode bit
// (RQ13) configuration area reachable only in program or verify mode
// (RQ14) configuration selects power-on, onp, clock option and lock, and applies them; the clock option bit is stored but drives nothing
// (RQ15) enabled sources merge into one request held until delay expires
// (RQ16) delay counts main clock and restarts when any source reasserts
`timescale 1ns/1ps
`default_nettype none
`include "rpfc_cfg.svh"
module rpfc_top #(
  parameter int unsigned STARTUP_CYC = `RPFC_STARTUP_CYC + `RPFC_EXTRA_CYC,
  parameter logic [15:0] VEC_ADDR    = 16'hfffe
) (
  input  wire logic        I_CLK,
  input  wire logic        I_RESET_N,
  input  wire logic        I_POR_LOW,
  input  wire logic        I_RST_PIN_N,
  input  wire logic        I_WDT_TIMEOUT,
  input  wire logic        I_SUPPLY_LOW,
  input  wire logic        I_FETCH_VALID,
  input  wire logic        I_FETCH_BAD,
  input  wire logic [7:0]  I_VEC_DATA,
  input  wire logic        I_PADDR_DUMMY,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             O_CORE_RESET,
  output logic             O_FREEZE,
  output logic             O_PORT3_BIT5_INPUT,
  output logic [7:0]       O_RAM_BANK_REGISTER,
  output logic             O_DPAGE_FLAG,
  output logic             O_CLK_SEL,
  output logic             O_ONP_CONFIG_OPTION,
  output logic             O_SECURITY_LOCK,
  output logic [15:0]      O_VEC_ADDR,
  output logic             O_VEC_RD,
  output logic [15:0]      O_START_PC,
  output logic             O_RUN
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  rpfc_pkg::rpfc_state_t state_r, state_nxt;
  rpfc_pkg::rpfc_src_t   src;
  logic [2:0]            supply_fail_control_reg;
  logic [4:0]            cfg_area_r;
  logic                  prog_mode_r;
  logic [4:0]            cause_r;
  logic                  pf_hit;
  logic                  req;
  logic                  delay_done;
  logic                  pin_as_port;
  logic                  vec_phase_r;
  logic [7:0]            vec_lo_r;
  logic                  wr_en;
  logic                  rd_en;

  // ---------------------------------------------------------------
  // source merge
  // ---------------------------------------------------------------
  // pin is a port only when both the power-on and port options are set
  assign pin_as_port = cfg_area_r[`RPFC_CFG_POR_BIT] && cfg_area_r[`RPFC_CFG_PORT_BIT]; // RQ3

  // each source is one bit; address fail needs a real fetch
  always_comb begin
    src.power_on    = I_POR_LOW;                                     // RQ2
    src.ext_pin     = !I_RST_PIN_N && !pin_as_port;                  // RQ8
    src.watchdog    = I_WDT_TIMEOUT;
    src.supply_fail = pf_hit && supply_fail_control_reg[`RPFC_PF_EN_BIT]
                      && !supply_fail_control_reg[`RPFC_PF_MODE_BIT];  // RQ11
    src.addr_fail   = I_FETCH_VALID && I_FETCH_BAD;                  // RQ10
  end

  assign req = |src; // RQ1 RQ15

  // the pin reads as a port bit; a reset pin reads high to stay harmless
  assign O_PORT3_BIT5_INPUT = pin_as_port ? I_RST_PIN_N : 1'b1;

  // ---------------------------------------------------------------
  // filters and delay
  // ---------------------------------------------------------------
  rpfc_filter #(
    .CYCLES (`RPFC_PF_FILT_CYC)
  ) u_pf_filter (
    .I_CLK     (I_CLK),
    .I_RESET_N (I_RESET_N),
    .i_level   (I_SUPPLY_LOW),
    .o_hit     (pf_hit)
  ); // RQ12

  rpfc_delay #(
    .CYCLES (STARTUP_CYC)
  ) u_delay (
    .I_CLK     (I_CLK),
    .I_RESET_N (I_RESET_N),
    .i_restart (req),
    .o_done    (delay_done)
  ); // RQ6 RQ16

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  // hold while requested, count after release, then fetch vector and run
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      rpfc_pkg::RPFC_ST_HOLD: begin
        if (!req) begin
          state_nxt = rpfc_pkg::RPFC_ST_COUNT;
        end
      end
      rpfc_pkg::RPFC_ST_COUNT: begin
        if (req) begin
          state_nxt = rpfc_pkg::RPFC_ST_HOLD; // RQ16
        end else if (delay_done && vec_phase_r) begin
          state_nxt = rpfc_pkg::RPFC_ST_RUN;
        end
      end
      rpfc_pkg::RPFC_ST_RUN: begin
        if (req) begin
          state_nxt = rpfc_pkg::RPFC_ST_HOLD;
        end
      end
      default: state_nxt = rpfc_pkg::RPFC_ST_HOLD;
    endcase
  end

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      state_r <= rpfc_pkg::RPFC_ST_HOLD;
    end else begin
      state_r <= state_nxt;
    end
  end

  // core stays in reset until the vector has been read
  assign O_CORE_RESET = (state_r != rpfc_pkg::RPFC_ST_RUN); // RQ15
  assign O_RUN        = (state_r == rpfc_pkg::RPFC_ST_RUN);

  // ---------------------------------------------------------------
  // reset vector fetch: low byte first, then high byte
  // ---------------------------------------------------------------
  assign O_VEC_RD   = (state_r == rpfc_pkg::RPFC_ST_COUNT) && delay_done;
  assign O_VEC_ADDR = vec_phase_r ? (VEC_ADDR + 16'h0001) : VEC_ADDR; // RQ9

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      vec_phase_r <= 1'b0;
      vec_lo_r    <= 8'h00;
      O_START_PC  <= 16'h0000;
    end else if (state_r != rpfc_pkg::RPFC_ST_COUNT || !delay_done) begin
      vec_phase_r <= 1'b0;
    end else if (!vec_phase_r) begin
      vec_lo_r    <= I_VEC_DATA;
      vec_phase_r <= 1'b1;
    end else begin
      O_START_PC  <= {I_VEC_DATA, vec_lo_r}; // RQ9
    end
  end

  // ---------------------------------------------------------------
  // core state initialised by internal reset; RAM has no reset here
  // ---------------------------------------------------------------
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_RAM_BANK_REGISTER <= `RPFC_RAMBANK_RST;
      O_DPAGE_FLAG        <= `RPFC_DPAGE_RST;
      O_CLK_SEL           <= `RPFC_CLKSEL_MAIN;
    end else if (O_CORE_RESET) begin
      O_RAM_BANK_REGISTER <= `RPFC_RAMBANK_RST; // RQ4 RQ7
      O_DPAGE_FLAG        <= `RPFC_DPAGE_RST;
      O_CLK_SEL           <= `RPFC_CLKSEL_MAIN;
    end else if (wr_en && paddr == `RPFC_ADDR_RAMBANK) begin
      O_RAM_BANK_REGISTER <= pwdata[7:0];
      O_DPAGE_FLAG        <= pwdata[8];
      O_CLK_SEL           <= pwdata[9];
    end
  end

  // ---------------------------------------------------------------
  // supply fail control and freeze
  // ---------------------------------------------------------------
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      supply_fail_control_reg <= `RPFC_PFCTL_RST;
    end else begin
      if (wr_en && paddr == `RPFC_ADDR_PFCTL) begin
        supply_fail_control_reg[1:0] <= pwdata[1:0];
        if (pwdata[`RPFC_PF_FLAG_BIT]) begin
          supply_fail_control_reg[`RPFC_PF_FLAG_BIT] <= 1'b0;
        end
      end
      // set beats clear
      if (pf_hit && supply_fail_control_reg[`RPFC_PF_EN_BIT]) begin
        supply_fail_control_reg[`RPFC_PF_FLAG_BIT] <= 1'b1; // RQ12
      end
    end
  end

  // freeze holds the core while the supply stays low in freeze mode
  assign O_FREEZE = pf_hit && supply_fail_control_reg[`RPFC_PF_EN_BIT]
                    && supply_fail_control_reg[`RPFC_PF_MODE_BIT]; // RQ11 RQ12

  // ---------------------------------------------------------------
  // configuration area and cause capture
  // ---------------------------------------------------------------
  // writes only land in program mode, and reads outside it return zero
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      cfg_area_r  <= `RPFC_CFG_RST;
      prog_mode_r <= 1'b0;
    end else begin
      if (wr_en && paddr == `RPFC_ADDR_PROGMODE) begin
        prog_mode_r <= pwdata[0];
      end
      if (wr_en && paddr == `RPFC_ADDR_CFG && prog_mode_r) begin
        cfg_area_r <= pwdata[4:0]; // RQ13
      end
    end
  end

  assign O_ONP_CONFIG_OPTION = cfg_area_r[`RPFC_CFG_ONP_BIT];  // RQ14
  assign O_SECURITY_LOCK     = cfg_area_r[`RPFC_CFG_LOCK_BIT];

  // sticky cause bits; a new cause wins over a software clear
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      cause_r <= 5'h00;
    end else begin
      cause_r <= ((wr_en && paddr == `RPFC_ADDR_CAUSE) ? (cause_r & ~pwdata[4:0]) : cause_r) | src;
    end
  end

  // ---------------------------------------------------------------
  // APB slave: zero wait, unmapped reads zero and flag error
  // ---------------------------------------------------------------
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && !penable && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && (paddr > `RPFC_ADDR_PROGMODE || paddr[1:0] != 2'b00);

  // read data registered in the setup cycle
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      if (paddr == `RPFC_ADDR_PFCTL) begin
        prdata <= {29'h0, supply_fail_control_reg};
      end else if (paddr == `RPFC_ADDR_CFG) begin
        prdata <= prog_mode_r ? {27'h0, cfg_area_r} : 32'h0; // RQ13
      end else if (paddr == `RPFC_ADDR_STATUS) begin
        prdata <= {28'h0, O_FREEZE, pin_as_port, state_r};
      end else if (paddr == `RPFC_ADDR_CAUSE) begin
        prdata <= {27'h0, cause_r};
      end else if (paddr == `RPFC_ADDR_RAMBANK) begin
        prdata <= {22'h0, O_CLK_SEL, O_DPAGE_FLAG, O_RAM_BANK_REGISTER};
      end else if (paddr == `RPFC_ADDR_PROGMODE) begin
        prdata <= {31'h0, prog_mode_r};
      end else begin
        prdata <= 32'h0;
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_source_resets: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    req |=> O_CORE_RESET) else $error("source did not hold core in reset"); // RQ1
  chk_por_holds: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    I_POR_LOW |=> state_r == rpfc_pkg::RPFC_ST_HOLD) else $error("power-on low not held"); // RQ2
  // with every other source quiet, a port pin must never stop a running core
  chk_pin_port: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    (pin_as_port && O_RUN && !I_POR_LOW && !I_WDT_TIMEOUT && !src.supply_fail
     && !(I_FETCH_VALID && I_FETCH_BAD)) |=> O_RUN) else $error("port pin caused reset"); // RQ3
  chk_ram_bank_clear: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    $rose(O_RUN) |-> O_RAM_BANK_REGISTER == `RPFC_RAMBANK_RST && O_DPAGE_FLAG == `RPFC_DPAGE_RST
      && O_CLK_SEL == `RPFC_CLKSEL_MAIN)
    else $error("core state not initialised"); // RQ4
  chk_delay_hold: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    $fell(req) |-> !O_RUN [*8]) else $error("ran before delay"); // RQ6
  chk_addr_fail: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    (I_FETCH_VALID && I_FETCH_BAD) |=> cause_r[4] && O_CORE_RESET)
    else $error("address fail missed"); // RQ10
  // a disabled detector neither freezes nor resets a core that nothing else resets
  chk_pf_disabled: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    (!supply_fail_control_reg[`RPFC_PF_EN_BIT] && O_RUN && !I_POR_LOW && I_RST_PIN_N
     && !I_WDT_TIMEOUT && !(I_FETCH_VALID && I_FETCH_BAD)) |-> !O_FREEZE ##1 O_RUN)
    else $error("disabled detector acted"); // RQ11
  chk_cfg_locked: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    !prog_mode_r |=> $stable(cfg_area_r)) else $error("config changed outside program mode"); // RQ13
  chk_vec_order: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    $rose(O_RUN) |-> O_START_PC == {$past(I_VEC_DATA), $past(vec_lo_r)})
    else $error("start address wrong"); // RQ9
endmodule : rpfc_top
`default_nettype wire

/* File: verif/rpfc_pin_drv.sv */
// Purpose: external reset circuit that pulls the reset pin low
// Assumes: pin has a pull-up, so it reads high when nothing pulls
// Notes:   a short request is stretched to the minimum low time
`timescale 1ns/1ps
`default_nettype none
module rpfc_pin_drv #(
  parameter int unsigned MIN_LOW = 8
) (
  input  wire logic       I_CLK,
  input  wire logic       i_go,
  input  wire logic [7:0] i_len,
  input  wire logic       i_hold_low,
  output logic            o_pin_n
);
  // ---------------------------------------------------------------
  // low-time counter
  // ---------------------------------------------------------------
  int unsigned left_r;

  // the circuit never pulses shorter than the pin needs to be seen
  always_ff @(posedge I_CLK) begin
    if (i_go) begin
      left_r <= (i_len < MIN_LOW) ? MIN_LOW : int'(i_len);
    end else if (left_r != 0) begin
      left_r <= left_r - 1;
    end
  end

  // pull-up wins once the pulse is over
  assign o_pin_n = !(i_hold_low || left_r != 0);
endmodule : rpfc_pin_drv
`default_nettype wire

/* File: verif/tb_rpfc_top.sv */
// Purpose: self-checking bench for the reset and supply-fail controller
// Assumes: start-up count shortened through STARTUP_CYC
// Notes:   drivers queue expected results, monitor compares them
`timescale 1ns/1ps
`default_nettype none
`include "rpfc_cfg.svh"
module tb_rpfc_top;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  localparam int unsigned STUP = 20;
  typedef struct packed {
    logic [31:0] data;
    logic        err;
    logic        use_data;
  } rpfc_note_t;
  logic        clk, reset_n, por_low, wdt, supply_low, fetch_valid, fetch_bad;
  logic        pin_go, pin_hold, pin_n, pf_en, port_mode, run_d;
  logic [7:0]  pin_len, vec_lo, vec_hi, vec_data, ram_bank;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed;
  logic        core_reset, freeze, port_bit, dpage, clk_sel, onp_config_option, lock, vec_rd, run;
  logic [15:0] vec_addr, start_pc, exp_pc;
  int          bad_count, tests_run, cyc, rel_at;
  logic [15:0] pc_q[$];
  rpfc_note_t  rd_q[$];
  rpfc_note_t  note;

  rpfc_top #(.STARTUP_CYC(STUP)) rpfc_top_inst (
    .I_CLK(clk), .I_RESET_N(reset_n), .I_POR_LOW(por_low), .I_RST_PIN_N(pin_n),
    .I_WDT_TIMEOUT(wdt), .I_SUPPLY_LOW(supply_low), .I_FETCH_VALID(fetch_valid),
    .I_FETCH_BAD(fetch_bad), .I_VEC_DATA(vec_data), .I_PADDR_DUMMY(1'b0),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .O_CORE_RESET(core_reset),
    .O_FREEZE(freeze), .O_PORT3_BIT5_INPUT(port_bit), .O_RAM_BANK_REGISTER(ram_bank),
    .O_DPAGE_FLAG(dpage), .O_CLK_SEL(clk_sel), .O_ONP_CONFIG_OPTION(onp_config_option),
    .O_SECURITY_LOCK(lock), .O_VEC_ADDR(vec_addr), .O_VEC_RD(vec_rd),
    .O_START_PC(start_pc), .O_RUN(run));

  rpfc_pin_drv rpfc_pin_drv_inst (
    .I_CLK(clk), .i_go(pin_go), .i_len(pin_len), .i_hold_low(pin_hold), .o_pin_n(pin_n));

  // vector memory answers in the same cycle, only while read; high byte sits at the top address
  assign vec_data = !vec_rd ? 8'h00 : (vec_addr == 16'hffff) ? vec_hi
                  : ((vec_addr == 16'hfffe) ? vec_lo : 8'h00);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    xs = v ^ (v << 5);
  endfunction : xs

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test

  // one apb transfer; an edge passes after release so calls never collide
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) bad_count++;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic use_d, input logic err);
    rd_q.push_back('{d, err, use_d});
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic wait_run();
    int n;
    n = 0;
    while (run !== 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    check("run", 32'(run), 32'h1);
    repeat (3) @(posedge clk);
  endtask : wait_run

  // fire one reset source k, optionally pulse the watchdog mid-count
  task automatic trig(input int k, input logic again);
    seed = xs(seed);
    apb(1'b1, `RPFC_ADDR_RAMBANK, {22'h0, seed[9:0] | 10'h001});
    check("bank set", 32'(ram_bank), {24'h0, seed[7:0] | 8'h01});
    vec_lo <= seed[23:16];
    vec_hi <= seed[31:24];
    pc_q.push_back(seed[31:16]);
    case (k)
      0: por_low <= 1'b1;
      1: begin
        pin_go  <= 1'b1;
        pin_len <= 8'h08 + {6'h0, seed[1:0]};
      end
      2: wdt <= 1'b1;
      3: supply_low <= 1'b1;
      default: begin
        fetch_valid <= 1'b1;
        fetch_bad   <= 1'b1;
      end
    endcase
    @(posedge clk);
    pin_go <= 1'b0;
    repeat (11) @(posedge clk);
    check("core reset", 32'(core_reset), 32'h1);
    por_low     <= 1'b0;
    wdt         <= 1'b0;
    supply_low  <= 1'b0;
    fetch_valid <= 1'b0;
    fetch_bad   <= 1'b0;
    if (again) begin
      repeat (10) @(posedge clk);
      wdt <= 1'b1;
      @(posedge clk);
      wdt <= 1'b0;
    end
    wait_run();
  endtask : trig

  // ---------------------------------------------------------------
  // monitor: pops notes when a start or a read answer appears
  // ---------------------------------------------------------------
  always @(posedge clk) cyc <= cyc + 1;

  always @(posedge clk) begin
    if (por_low || (!pin_n && !port_mode) || wdt || (supply_low && pf_en) || (fetch_valid && fetch_bad)) begin
      rel_at <= cyc;
    end
    run_d <= run;
    if (run === 1'b1 && run_d !== 1'b1) begin
      if (pc_q.size() == 0) begin
        check("unexpected start", 32'h1, 32'h0);
      end else begin
        exp_pc = pc_q.pop_front();
        check("start pc", 32'(start_pc), 32'(exp_pc));
        check("ram bank", 32'(ram_bank), 32'(`RPFC_RAMBANK_RST));
        check("dpage", 32'(dpage), 32'(`RPFC_DPAGE_RST));
        check("clk sel", 32'(clk_sel), 32'(`RPFC_CLKSEL_MAIN));
        check("span", 32'(cyc - rel_at >= STUP && cyc - rel_at <= STUP + 6), 32'h1);
      end
    end
    if (psel && penable && !pwrite && pready === 1'b1 && rd_q.size() > 0) begin
      note = rd_q.pop_front();
      if (note.use_data) check("read data", prdata, note.data);
      check("slave error", 32'(pslverr), 32'(note.err));
    end
  end

  // ---------------------------------------------------------------
  // clock, watchdog, main sequence
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    stop_test();
  end

  initial begin
    {reset_n, wdt, supply_low, fetch_valid, fetch_bad, pin_go, pin_hold} = '0;
    {psel, penable, pwrite, pf_en, port_mode} = '0;
    por_low = 1'b1;
    pin_len = 8'h08;
    paddr   = 12'h000;
    pwdata  = 32'h0;
    seed    = 32'h6e6341e4;
    vec_lo  = 8'h34;
    vec_hi  = 8'h12;
    pc_q.push_back(16'h1234);
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    repeat (5) @(posedge clk);
    por_low <= 1'b0;
    wait_run();
    // supply fail off, then too short, then freeze mode
    apb(1'b1, `RPFC_ADDR_PFCTL, 32'h0);
    supply_low <= 1'b1;
    repeat (20) @(posedge clk);
    check("pf off reset", 32'(core_reset), 32'h0);
    check("pf off freeze", 32'(freeze), 32'h0);
    supply_low <= 1'b0;
    pf_en <= 1'b1;
    apb(1'b1, `RPFC_ADDR_PFCTL, 32'h3);
    supply_low <= 1'b1;
    repeat (5) @(posedge clk);
    supply_low <= 1'b0;
    repeat (3) @(posedge clk);
    check("short dip", 32'({core_reset, freeze}), 32'h0);
    supply_low <= 1'b1;
    repeat (15) @(posedge clk);
    check("freeze", 32'({core_reset, freeze}), 32'h1);
    supply_low <= 1'b0;
    apb(1'b1, `RPFC_ADDR_PFCTL, 32'h5);
    // configuration area guarded outside program mode
    apb(1'b1, `RPFC_ADDR_CFG, 32'h17);
    rd(`RPFC_ADDR_CFG, 32'h0, 1'b1, 1'b0);
    apb(1'b1, `RPFC_ADDR_PROGMODE, 32'h1);
    apb(1'b1, `RPFC_ADDR_CFG, 32'h17);
    rd(`RPFC_ADDR_CFG, 32'h17, 1'b1, 1'b0);
    check("onp lock", 32'({onp_config_option, lock}), 32'h3);
    check("port idle", 32'(port_bit), 32'h1);
    port_mode <= 1'b1;
    pin_hold  <= 1'b1;
    repeat (12) @(posedge clk);
    check("pin as port", 32'({core_reset, port_bit}), 32'h0);
    pin_hold <= 1'b0;
    apb(1'b1, `RPFC_ADDR_CFG, 32'h0);
    port_mode <= 1'b0;
    apb(1'b1, `RPFC_ADDR_PROGMODE, 32'h0);
    rd(12'h018, 32'h0, 1'b0, 1'b1);
    // every reset source, then two runs with a restart during the count
    for (int k = 0; k < 5; k++) begin
      trig(k, 1'b0);
    end
    trig(2, 1'b1);
    trig(1, 1'b1);
    stop_test();
  end
endmodule : tb_rpfc_top
`default_nettype wire
